// ===== core/bss_regs.svh
// Register map, field positions, reset values and gap counts of the buffered serial unit.
// Assumes byte-wide registers on a 16-bit address port; included by bare name.
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH

// ****************************************
// Address map
// ****************************************
`define BSS_BUF_BASE 16'hFF80
`define BSS_BUF_LAST 16'hFF9F
`define BSS_START_PTR_ADDR 16'hFFA0
`define BSS_END_PTR_ADDR 16'hFFA1
`define BSS_CTRL_ADDR 16'hFFA2
`define BSS_STATUS_ADDR 16'hFFA3

// ****************************************
// Field positions
// ****************************************
`define BSS_CTRL_DIR_BIT 4
`define BSS_CTRL_GAP_HI 3
`define BSS_CTRL_GAP_LO 2
`define BSS_CTRL_CLK_HI 1
`define BSS_CTRL_CLK_LO 0
`define BSS_STAT_FINAL_BIT 4
`define BSS_STAT_OVR_BIT 3
`define BSS_STAT_WT_BIT 2
`define BSS_STAT_GIT_BIT 1
`define BSS_STAT_BUSY_BIT 0

// ****************************************
// Reset and fixed values
// ****************************************
`define BSS_RESERVED_ONES 3'h7
`define BSS_RESET_VALUE 8'hE0
`define BSS_BUSY_READ 8'hFF
`define BSS_UNMAPPED_READ 8'h00

// ****************************************
// Clock selection codes and timing counts
// ****************************************
`define BSS_CLK_DIV2 2'h0
`define BSS_CLK_DIV4 2'h1
`define BSS_CLK_DIV8 2'h2
`define BSS_CLK_EXT 2'h3
`define BSS_HALF_DIV2 3'h1
`define BSS_HALF_DIV4 3'h2
`define BSS_HALF_DIV8 3'h4
`define BSS_GAP_HALVES_00 5'h00
`define BSS_GAP_HALVES_01 5'h02
`define BSS_GAP_HALVES_10 5'h04
`define BSS_GAP_HALVES_11 5'h10

`endif

// ===== core/bss_pkg.sv
// Types shared by the buffered serial unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bss_pkg;

    // ****************************************
    // Transfer engine states
    // ****************************************
    typedef enum logic {
        BSS_IDLE,
        BSS_SHIFT
    } bss_state_t;

endpackage

// ===== core/bss_clk_gen.sv
// Internal serial clock generator: divides ref_clk by 2, 4 or 8.
// Assumes the caller raises hold only while the clock is high.
`timescale 1ns/100ps
`include "bss_regs.svh"

module bss_clk_gen
    import bss_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic hold,
    input wire logic [1:0] div_sel,
    // Clock and phase events
    output logic sck_level,
    output logic half_tick,
    output logic fall_tick,
    output logic rise_tick
);

    logic [2:0] half_len;
    logic [2:0] cnt_q;
    logic level_q;

    always_comb
    begin
        case (div_sel)
            `BSS_CLK_DIV2: half_len = `BSS_HALF_DIV2;
            `BSS_CLK_DIV4: half_len = `BSS_HALF_DIV4;
            `BSS_CLK_DIV8: half_len = `BSS_HALF_DIV8;
            default: half_len = `BSS_HALF_DIV2;
        endcase
    end

    assign half_tick = run && (cnt_q == half_len - 3'h1);
    assign fall_tick = half_tick && level_q && !hold;
    assign rise_tick = half_tick && !level_q;
    assign sck_level = level_q;

    // Even high and low phases from one half-period counter
    always_ff @(posedge ref_clk)
    begin
        if (rst || !run || half_tick)
        begin
            cnt_q <= 3'h0;
        end
        else
        begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Idles high; a hold keeps the high phase running through a gap
    always_ff @(posedge ref_clk)
    begin
        if (rst || !run)
        begin
            level_q <= 1'b1;
        end
        else if (half_tick && !hold)
        begin
            level_q <= !level_q;
        end
    end

endmodule

// ===== core/bss_buffered_serial.sv
// Buffered synchronous serial unit: 32-byte buffer, pointer, control and status registers.
// Assumes a register master with one-cycle strobes and an outside pin mux resolving sck.
//
// Contract
// - 32-byte buffer, CPU access only when idle
// - Start pointer: 5-bit field, first byte
// - End pointer: 5-bit field, last byte
// - Bytes move start through end unattended
// - Equal pointers move exactly one byte
// - Upper three bits read one, ignore writes
// - Pointers and control reset to E0
// - Status resets E0, overrun may differ
// - Direction bit: zero receive, one transmit
// - Gap field stretches clock high phase
// - Gaps only with internal clock
// - Gap divisions every 8 or 16 bits
// - Clock select: divide 2/4/8 or external
// - Final bit captured and drives data out
// - Overrun on excess clocking
// - Status write clears overrun and waiting
// - Busy buffer access ignored, flags raised
// - Start bit starts, shows busy, aborts
// - Start above end wraps through top
// - LSB first, out on fall, in on rise
// - Gap interval zero 16 bits, one 8
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "bss_regs.svh"

module bss_buffered_serial
    import bss_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    // Serial data and select pins
    input wire logic si_in,
    output logic so_out,
    output logic cs_n,
    // Request to the interrupt controller
    output logic serial_request_flag
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [15:0] BUF_BASE = `BSS_BUF_BASE;

    logic [7:0] buf_mem [0:31];
    logic [4:0] start_index_field_q;
    logic [4:0] end_index_field_q;
    logic dir_q;
    logic gap_length_high_q;
    logic gap_length_low_q;
    logic clock_select_high_q;
    logic clock_select_low_q;
    logic final_output_bit_q;
    logic overrun_flag_q;
    logic busy_access_flag_q;
    logic gap_interval_select_q;
    bss_state_t state_q;
    logic [4:0] idx_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shreg_q;
    logic tx_bit_q;
    logic [4:0] gap_cnt_q;
    logic [7:0] rdata_q;
    logic req_q;

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] filt_q;
    logic sck_prev_q;

    logic busy;
    logic ext_clk;
    logic [1:0] clk_sel;
    logic [1:0] gap_sel;
    logic buf_hit;
    logic wr_start_ptr;
    logic wr_end_ptr;
    logic wr_ctrl;
    logic wr_status;
    logic start_req;
    logic abort_req;
    logic gen_level;
    logic gen_half;
    logic gen_fall;
    logic gen_rise;
    logic ext_rise;
    logic ext_fall;
    logic sck_f;
    logic si_f;
    logic rise;
    logic fall;
    logic byte_end;
    logic last_byte;
    logic division;
    logic done;
    logic wt_set;
    logic ovr_set;
    logic [4:0] idx_next;
    logic [7:0] rx_byte;
    logic [4:0] gap_halves;
    logic [7:0] rd_val;

    // ****************************************
    // Decode
    // ****************************************
    assign busy = (state_q == BSS_SHIFT);
    assign clk_sel = {clock_select_high_q, clock_select_low_q};
    assign gap_sel = {gap_length_high_q, gap_length_low_q};
    assign ext_clk = (clk_sel == `BSS_CLK_EXT);
    assign buf_hit = (reg_addr[15:5] == BUF_BASE[15:5]);
    assign wr_start_ptr = reg_wr && (reg_addr == `BSS_START_PTR_ADDR);
    assign wr_end_ptr = reg_wr && (reg_addr == `BSS_END_PTR_ADDR);
    assign wr_ctrl = reg_wr && (reg_addr == `BSS_CTRL_ADDR);
    assign wr_status = reg_wr && (reg_addr == `BSS_STATUS_ADDR);
    assign start_req = wr_status && reg_wdata[`BSS_STAT_BUSY_BIT] && !busy;
    assign abort_req = wr_status && !reg_wdata[`BSS_STAT_BUSY_BIT] && busy;

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    // Level moves once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                    sync3_q[gi] <= 1'b1;
                    filt_q[gi] <= 1'b1;
                end
                else
                begin
                    sync1_q[gi] <= (gi == 0) ? sck_in : si_in;
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi])
                    begin
                        filt_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    assign sck_f = filt_q[0];
    assign si_f = filt_q[1];

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sck_prev_q <= 1'b1;
        end
        else
        begin
            sck_prev_q <= sck_f;
        end
    end

    assign ext_rise = sck_f && !sck_prev_q;
    assign ext_fall = !sck_f && sck_prev_q;

    // ****************************************
    // Serial clock source
    // ****************************************
    bss_clk_gen u_clk_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(busy && !ext_clk),
        .hold(gap_cnt_q != 5'h00),
        .div_sel(clk_sel),
        .sck_level(gen_level),
        .half_tick(gen_half),
        .fall_tick(gen_fall),
        .rise_tick(gen_rise)
    );

    assign rise = busy && (ext_clk ? ext_rise : gen_rise);
    assign fall = busy && (ext_clk ? ext_fall : gen_fall);
    assign byte_end = rise && (bitcnt_q[2:0] == 3'h7);
    assign last_byte = (idx_q == end_index_field_q);
    assign done = byte_end && last_byte;
    assign idx_next = idx_q + 5'h01;
    assign rx_byte = {si_f, shreg_q[7:1]};
    // Division at each byte, or every other byte when the interval bit is zero
    assign division = gap_interval_select_q || bitcnt_q[3];

    always_comb
    begin
        case (gap_sel)
            2'h0: gap_halves = `BSS_GAP_HALVES_00;
            2'h1: gap_halves = `BSS_GAP_HALVES_01;
            2'h2: gap_halves = `BSS_GAP_HALVES_10;
            default: gap_halves = `BSS_GAP_HALVES_11;
        endcase
    end

    // ****************************************
    // Transfer state
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= BSS_IDLE;
        end
        else
        begin
            case (state_q)
                BSS_IDLE:
                begin
                    if (start_req)
                    begin
                        state_q <= BSS_SHIFT;
                    end
                end
                BSS_SHIFT:
                begin
                    if (abort_req || done)
                    begin
                        state_q <= BSS_IDLE;
                    end
                end
                default:
                begin
                    state_q <= BSS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            idx_q <= 5'h00;
            bitcnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_bit_q <= 1'b0;
        end
        else if (start_req)
        begin
            idx_q <= start_index_field_q;
            bitcnt_q <= 4'h0;
            shreg_q <= buf_mem[start_index_field_q];
            tx_bit_q <= final_output_bit_q;
        end
        else if (busy)
        begin
            if (fall)
            begin
                tx_bit_q <= shreg_q[0];
            end
            if (rise)
            begin
                bitcnt_q <= bitcnt_q + 4'h1;
                if (byte_end)
                begin
                    idx_q <= idx_next;
                    shreg_q <= buf_mem[idx_next];
                end
                else
                begin
                    shreg_q <= rx_byte;
                end
            end
        end
    end

    // Gap counter in half periods, only for the internal clock
    always_ff @(posedge ref_clk)
    begin
        if (rst || !busy)
        begin
            gap_cnt_q <= 5'h00;
        end
        else if (byte_end && division && !last_byte && !ext_clk)
        begin
            gap_cnt_q <= gap_halves;
        end
        else if (gap_cnt_q != 5'h00 && gen_half)
        begin
            gap_cnt_q <= gap_cnt_q - 5'h01;
        end
    end

    // ****************************************
    // Data buffer
    // ****************************************
    // No reset: contents are undefined until written
    always_ff @(posedge ref_clk)
    begin
        if (reg_wr && buf_hit && !busy)
        begin
            buf_mem[reg_addr[4:0]] <= reg_wdata;
        end
        else if (byte_end && !dir_q)
        begin
            buf_mem[idx_q] <= rx_byte;
        end
    end

    // ****************************************
    // Pointer and control registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            start_index_field_q <= 5'h00;
            end_index_field_q <= 5'h00;
        end
        else
        begin
            if (wr_start_ptr)
            begin
                start_index_field_q <= reg_wdata[4:0];
            end
            if (wr_end_ptr)
            begin
                end_index_field_q <= reg_wdata[4:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dir_q <= 1'b0;
            gap_length_high_q <= 1'b0;
            gap_length_low_q <= 1'b0;
            clock_select_high_q <= 1'b0;
            clock_select_low_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            dir_q <= reg_wdata[`BSS_CTRL_DIR_BIT];
            gap_length_high_q <= reg_wdata[`BSS_CTRL_GAP_HI];
            gap_length_low_q <= reg_wdata[`BSS_CTRL_GAP_LO];
            clock_select_high_q <= reg_wdata[`BSS_CTRL_CLK_HI];
            clock_select_low_q <= reg_wdata[`BSS_CTRL_CLK_LO];
        end
    end

    // ****************************************
    // Status register
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            final_output_bit_q <= 1'b0;
            gap_interval_select_q <= 1'b0;
        end
        else if (wr_status)
        begin
            final_output_bit_q <= reg_wdata[`BSS_STAT_FINAL_BIT];
            gap_interval_select_q <= reg_wdata[`BSS_STAT_GIT_BIT];
        end
        else if (done && dir_q)
        begin
            final_output_bit_q <= tx_bit_q;
        end
    end

    // Peer clocking an idle external-clock unit means data beyond the area
    assign ovr_set = ext_clk && !busy && ext_rise;
    assign wt_set = busy && buf_hit && (reg_wr || reg_rd);

    // A set in the same cycle as the clearing write wins
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            overrun_flag_q <= 1'b0;
            busy_access_flag_q <= 1'b0;
        end
        else
        begin
            if (ovr_set)
            begin
                overrun_flag_q <= 1'b1;
            end
            else if (wr_status)
            begin
                overrun_flag_q <= 1'b0;
            end
            if (wt_set)
            begin
                busy_access_flag_q <= 1'b1;
            end
            else if (wr_status)
            begin
                busy_access_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read port and request
    // ****************************************
    always_comb
    begin
        rd_val = `BSS_UNMAPPED_READ;
        if (buf_hit)
        begin
            rd_val = busy ? `BSS_BUSY_READ : buf_mem[reg_addr[4:0]];
        end
        else
        begin
            case (reg_addr)
                `BSS_START_PTR_ADDR: rd_val = {`BSS_RESERVED_ONES, start_index_field_q};
                `BSS_END_PTR_ADDR: rd_val = {`BSS_RESERVED_ONES, end_index_field_q};
                `BSS_CTRL_ADDR: rd_val = {`BSS_RESERVED_ONES, dir_q, gap_sel, clk_sel};
                `BSS_STATUS_ADDR: rd_val = {`BSS_RESERVED_ONES, final_output_bit_q, overrun_flag_q,
                    busy_access_flag_q, gap_interval_select_q, busy};
                default: rd_val = `BSS_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
            req_q <= 1'b0;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_val : 8'h00;
            req_q <= done || wt_set;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = rdata_q;
    assign serial_request_flag = req_q;
    assign sck_out = gen_level;
    assign sck_oe_n = ext_clk;
    assign so_out = (busy && dir_q) ? tx_bit_q : final_output_bit_q;
    // Select only drives for internal-clock transmit, held low through gaps
    assign cs_n = !(busy && dir_q && !ext_clk);

endmodule

// ===== verification/bss_buffered_serial_properties.sv
// Port checks of the buffered serial unit.
// Bound onto the unit; one clock, synchronous reset.
`timescale 1ns/100ps
`include "bss_regs.svh"

module bss_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and request
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic so_out,
    input wire logic cs_n,
    input wire logic serial_request_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ****************************************
    // Sequences and properties
    // ****************************************
    // Aborts raise select too
    sequence s_done;
        $rose(cs_n) && !$past(reg_wr);
    endsequence
    sequence s_buf_busy;
        (reg_rd || reg_wr) && !cs_n && reg_addr >= `BSS_BUF_BASE && reg_addr <= `BSS_BUF_LAST;
    endsequence
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_so_moves;
        $changed(so_out) |-> $fell(sck_out) || $past(reg_wr);
    endproperty
    property p_oe_src;
        $changed(sck_oe_n) |-> $past(reg_wr) && $past(reg_addr) == `BSS_CTRL_ADDR;
    endproperty
    property p_sck_low_short;
        $fell(sck_out) |-> ##[1:4] sck_out;
    endproperty
    property p_ext_idle;
        sck_oe_n |-> sck_out;
    endproperty
    property p_cs_start;
        $fell(cs_n) |-> $past(reg_wr) && $past(reg_addr) == `BSS_STATUS_ADDR && $past(reg_wdata[0]);
    endproperty
    property p_req_pulse;
        serial_request_flag |=> !serial_request_flag;
    endproperty
    property p_done_req;
        s_done |-> ##[0:2] serial_request_flag;
    endproperty
    property p_busy_req;
        s_buf_busy |-> ##[1:2] serial_request_flag;
    endproperty
    property p_cs_internal;
        !cs_n |-> !sck_oe_n;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata not zero");
    a_so_moves: assert property (p_so_moves)
        else $error("so moved off fall");
    a_oe_src: assert property (p_oe_src)
        else $error("oe moved unprompted");
    a_sck_low_short: assert property (p_sck_low_short)
        else $error("sck low too long");
    a_ext_idle: assert property (p_ext_idle)
        else $error("sck not idle high");
    a_cs_start: assert property (p_cs_start)
        else $error("select fell unprompted");
    a_req_pulse: assert property (p_req_pulse)
        else $error("request too long");
    a_done_req: assert property (p_done_req)
        else $error("no done request");
    a_busy_req: assert property (p_busy_req)
        else $error("no busy request");
    a_cs_internal: assert property (p_cs_internal)
        else $error("select in ext mode");
endmodule

// ===== verification/bss_peer.sv
// Serial peer: captures, shifts and pulses a clock.
// Assumes the resolved clock pin level.
`timescale 1ns/100ps

module bss_peer (
    // Clock
    input wire logic ref_clk,
    // Pins seen
    input wire logic sck,
    input wire logic so,
    // Bench control
    input wire logic load,
    input wire logic [7:0] load_byte,
    input wire logic pulse,
    // Pins driven
    output logic si,
    output logic sck_ext,
    output logic [15:0] rx_word
);
    logic sck_q = 1'b1;
    logic [7:0] sh_q = 8'h00;
    logic [3:0] pulse_q = 4'h0;

    assign si = sh_q[0];
    // Pulled-up clock line idles high
    assign sck_ext = (pulse_q == 4'h0);

    always_ff @(posedge ref_clk)
    begin
        sck_q <= sck;
        if (sck && !sck_q)
            rx_word <= {so, rx_word[15:1]};
        // Data stays a period for the synchroniser
        if (load)
            sh_q <= load_byte;
        else if (sck && !sck_q)
            sh_q <= {~sh_q[0], sh_q[7:1]};
        if (pulse)
            pulse_q <= 4'h8;
        else if (pulse_q != 4'h0)
            pulse_q <= pulse_q - 4'h1;
    end
endmodule

// ===== verification/tb.sv
// Bench for the buffered serial unit.
// Assumes header and package compiled first.
`timescale 1ns/100ps
`include "bss_regs.svh"

module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sck_out, sck_oe_n, si_in, so_out, cs_n, serial_request_flag, sck_ext, sck_pin;
    logic load = 1'b0;
    logic [7:0] load_byte = 8'h00;
    logic pulse = 1'b0;
    logic [15:0] rx_word;
    logic [7:0] rd_val;
    int err_total = 0;
    int samples_checked = 0;
    int req_cnt = 0;
    int run_len = 0;
    int max_run = 0;

    always #5 ref_clk = ~ref_clk;
    assign sck_pin = sck_oe_n ? sck_ext : sck_out;

    bss_buffered_serial dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_pin), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .si_in(si_in), .so_out(so_out), .cs_n(cs_n),
        .serial_request_flag(serial_request_flag));
    bss_peer peer (.ref_clk(ref_clk), .sck(sck_pin), .so(so_out), .load(load), .load_byte(load_byte),
        .pulse(pulse), .si(si_in), .sck_ext(sck_ext), .rx_word(rx_word));

    // Request count and longest selected clock-high run
    always @(posedge ref_clk)
    begin
        if (serial_request_flag === 1'b1)
            req_cnt++;
        run_len = (cs_n === 1'b0 && sck_pin === 1'b1) ? run_len + 1 : 0;
        if (run_len > max_run)
            max_run = run_len;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        $display("Checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic rc(input string what, input logic [15:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, {8'h00, exp}, {8'h00, rd_val});
    endtask

    // Status reads poll here until the unit is idle
    task automatic wait_idle();
        for (int i = 0; i < 400; i++)
        begin
            rd(`BSS_STATUS_ADDR);
            if (rd_val[0] === 1'b0)
                return;
        end
        err_total++;
        $display("BAD busy wait expected 0 seen 1");
        end_sim();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        for (logic [15:0] a = `BSS_START_PTR_ADDR; a <= `BSS_STATUS_ADDR; a++)
            rc("reset value", a, 8'hE0);
        rc("unmapped", 16'hFFA4, 8'h00);
        for (logic [15:0] a = `BSS_START_PTR_ADDR; a <= `BSS_CTRL_ADDR; a++)
        begin
            wr(a, 8'hFF);
            rc("all ones", a, 8'hFF);
            wr(a, 8'h00);
            rc("reserved ones", a, 8'hE0);
        end
        wr(`BSS_BUF_LAST, 8'h22);
        rc("buffer top", `BSS_BUF_LAST, 8'h22);
    endtask

    task automatic t_tx_one();
        int c0;
        wr(`BSS_BUF_BASE + 16'h5, 8'hA5);
        wr(`BSS_BUF_BASE + 16'h6, 8'h00);
        wr(`BSS_START_PTR_ADDR, 8'h05);
        wr(`BSS_END_PTR_ADDR, 8'h05);
        wr(`BSS_CTRL_ADDR, 8'h10);
        c0 = req_cnt;
        wr(`BSS_STATUS_ADDR, 8'h01);
        wait_idle();
        chk("one byte sent", 16'h00A5, {8'h00, rx_word[15:8]});
        rc("final bit", `BSS_STATUS_ADDR, 8'hF0);
        chk("idle data out", 16'h0001, {15'h0000, so_out});
        chk("completion requests", 16'h0001, 16'(req_cnt - c0));
    endtask

    task automatic t_tx_wrap();
        wr(`BSS_BUF_LAST, 8'h3C);
        wr(`BSS_BUF_BASE, 8'hC3);
        wr(`BSS_START_PTR_ADDR, 8'h1F);
        wr(`BSS_END_PTR_ADDR, 8'h00);
        wr(`BSS_CTRL_ADDR, 8'h1D);
        max_run = 0;
        wr(`BSS_STATUS_ADDR, 8'h03);
        wait_idle();
        chk("wrapped bytes", 16'hC33C, rx_word);
        // Half period 2 plus eight periods of 4 cycles
        chk("gap length", 16'(2 + 8 * 4), 16'(max_run));
        rc("status after wrap", `BSS_STATUS_ADDR, 8'hF2);
    endtask

    task automatic t_busy();
        wr(`BSS_CTRL_ADDR, 8'h12);
        wr(`BSS_END_PTR_ADDR, 8'h03);
        wr(`BSS_STATUS_ADDR, 8'h01);
        rc("busy buffer read", `BSS_BUF_BASE, 8'hFF);
        wr(`BSS_BUF_BASE, 8'h00);
        rc("waiting flag", `BSS_STATUS_ADDR, 8'hE5);
        wr(`BSS_STATUS_ADDR, 8'h00);
        rc("abort clears", `BSS_STATUS_ADDR, 8'hE0);
        rc("buffer kept", `BSS_BUF_BASE, 8'hC3);
        rc("pointer kept", `BSS_END_PTR_ADDR, 8'hE3);
    endtask

    task automatic t_rx();
        wr(`BSS_CTRL_ADDR, 8'h02);
        wr(`BSS_START_PTR_ADDR, 8'h07);
        wr(`BSS_END_PTR_ADDR, 8'h07);
        @(posedge ref_clk);
        load <= 1'b1;
        load_byte <= 8'h5A;
        @(posedge ref_clk);
        load <= 1'b0;
        wr(`BSS_STATUS_ADDR, 8'h01);
        wait_idle();
        rc("received byte", `BSS_BUF_BASE + 16'h7, 8'h5A);
    endtask

    task automatic t_ovr();
        wr(`BSS_CTRL_ADDR, 8'h03);
        @(posedge ref_clk);
        pulse <= 1'b1;
        @(posedge ref_clk);
        pulse <= 1'b0;
        for (int i = 0; i < 20; i++)
        begin
            rd(`BSS_STATUS_ADDR);
            if (rd_val[3] === 1'b1)
                break;
        end
        chk("overrun", 16'h0001, {15'h0000, rd_val[3]});
        wr(`BSS_STATUS_ADDR, 8'h00);
        rc("overrun cleared", `BSS_STATUS_ADDR, 8'hE0);
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_tx_one();
        t_tx_wrap();
        t_busy();
        t_rx();
        t_ovr();
        end_sim();
    end
endmodule

bind bss_buffered_serial bss_props u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .so_out(so_out), .cs_n(cs_n), .serial_request_flag(serial_request_flag));
